// >>> design/lcd_pkg.sv
/*
 package for the compatibility decode block: register map, field positions,
 reset values, feature and flag bit positions, decode classes and state types.
 assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package lcd_pkg;

	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFF_FEATURE = 8'h00;
	localparam logic [7:0] OFF_VERSION = 8'h04;
	localparam logic [7:0] OFF_OPCODE = 8'h08;
	localparam logic [7:0] OFF_RESULT = 8'h0C;
	localparam logic [7:0] OFF_FLAGS = 8'h10;
	localparam logic [7:0] OFF_CTRL = 8'h14;
	localparam logic [7:0] OFF_STACK = 8'h18;
	localparam logic [7:0] OFF_CMD = 8'h1C;
	localparam logic [7:0] OFF_IMAGE = 8'h20;
	localparam logic [7:0] OFF_PUSHED = 8'h24;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// feature result word bit positions
	localparam int FEAT_FPU = 0;
	localparam int FEAT_TSC = 4;
	localparam int FEAT_MSR = 5;
	localparam int FEAT_CX8 = 8;
	localparam int FEAT_CMOV = 15;
	localparam int FEAT_SIMD = 23;

	// version result word fields
	localparam int VER_STEP_LSB = 0;
	localparam int VER_MODEL_LSB = 4;
	localparam int VER_FAMILY_LSB = 8;
	localparam logic [3:0] FAMILY_NEWER = 4'h6;

	// processor flag word
	localparam int FLG_FIXED_ONE = 1;
	localparam int FLG_RSVD15 = 15;
	localparam int FLG_ALIGN = 18;
	localparam int FLG_VINT = 19;
	localparam int FLG_VPEND = 20;
	localparam int FLG_QUERY = 21;
	localparam logic [31:0] FLG_BASE_MASK = 32'h0003_7FD5;
	localparam logic [31:0] FLG_RESET = 32'h0000_0002;

	// opcode register fields
	localparam int OPC_FIRST_LSB = 0;
	localparam int OPC_SECOND_LSB = 8;
	localparam int OPC_MODRM_LSB = 16;
	localparam int OPC_W = 24;
	localparam logic [7:0] ESC_TWO_BYTE = 8'h0F;

	// result register fields
	localparam int RES_DONE = 0;
	localparam int RES_FAULT = 1;
	localparam int RES_CLASS_LSB = 4;

	// control and command bits
	localparam int CTRL_REAL_MODE = 0;
	localparam int CMD_PUSH_FLAGS = 0;
	localparam int CMD_PUSH_FRAME = 1;
	localparam int CMD_PUSH_STACK = 2;
	localparam logic [31:0] STACK_WORD = 32'h0000_0004;

	// interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_DECODE = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_PUSH = 2;

	typedef enum logic [3:0] {
		LCD_CLS_BASE,
		LCD_CLS_ADDED,
		LCD_CLS_CACHE,
		LCD_CLS_MGMT,
		LCD_CLS_QUERY,
		LCD_CLS_CMOV,
		LCD_CLS_FLOAT,
		LCD_CLS_TSC,
		LCD_CLS_MSR,
		LCD_CLS_CX8,
		LCD_CLS_PERF,
		LCD_CLS_SIMD,
		LCD_CLS_TRAP,
		LCD_CLS_TESTREG,
		LCD_CLS_UNDEF
	} lcd_class_t;

	typedef struct packed {
		logic [31:0] feature;
		logic [3:0] family;
		logic has_mgmt;
		logic has_query;
	} lcd_cfg_t;

	typedef struct packed {
		logic fault;
		lcd_class_t cls;
	} lcd_dec_out_t;

	typedef struct packed {
		logic [31:0] word;
		logic [31:0] image;
	} lcd_flag_state_t;

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [OPC_W-1:0] opcode;
		logic dec_pend;
		logic [7:0] result;
		logic fault_pulse;
		logic real_mode;
		logic [31:0] stack;
		logic [31:0] pushed_stack;
		logic [31:0] image;
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
	} lcd_top_state_t;

	localparam lcd_top_state_t TOP_RESET = '0;

	function automatic logic [31:0] lcd_merge(logic [31:0] old_val, logic [31:0] new_val, logic [3:0] strb);
		logic [31:0] r;
		r = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// >>> design/lcd_decode.sv
/*
 opcode classifier: sorts a one- or two-byte opcode with its modrm byte into a
 class and flags the invalid-opcode fault.
 assumes the opcode word is held stable in flops by the caller.
*/
`timescale 1ns/1ps
module lcd_decode (
	input lcd_pkg::lcd_cfg_t cfg,
	input logic [lcd_pkg::OPC_W-1:0] opcode,
	output lcd_pkg::lcd_dec_out_t dec
);

	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] m;
	logic mem_form;
	logic ok;
	lcd_pkg::lcd_class_t cls;

	assign b0 = opcode[lcd_pkg::OPC_FIRST_LSB +: 8];
	assign b1 = opcode[lcd_pkg::OPC_SECOND_LSB +: 8];
	assign m = opcode[lcd_pkg::OPC_MODRM_LSB +: 8];
	assign mem_form = (m[7:6] != 2'h3);

	always_comb
	begin
		cls = lcd_pkg::LCD_CLS_BASE;
		if (b0 == lcd_pkg::ESC_TWO_BYTE)
		begin
			case (b1) inside
				8'h24, 8'h26: cls = lcd_pkg::LCD_CLS_TESTREG;
				8'h0B: cls = lcd_pkg::LCD_CLS_TRAP;
				[8'hC8:8'hCF], 8'hC0, 8'hC1, 8'hB0, 8'hB1: cls = lcd_pkg::LCD_CLS_ADDED;
				8'h08, 8'h09: cls = lcd_pkg::LCD_CLS_CACHE;
				8'h01: cls = (m[5:3] == 3'h7 && mem_form) ? lcd_pkg::LCD_CLS_CACHE : lcd_pkg::LCD_CLS_BASE;
				8'hAA: cls = lcd_pkg::LCD_CLS_MGMT;
				8'hA2: cls = lcd_pkg::LCD_CLS_QUERY;
				[8'h40:8'h4F]: cls = lcd_pkg::LCD_CLS_CMOV;
				8'h31: cls = lcd_pkg::LCD_CLS_TSC;
				8'h30, 8'h32: cls = lcd_pkg::LCD_CLS_MSR;
				8'h33: cls = lcd_pkg::LCD_CLS_PERF;
				8'hC7: cls = (m[5:3] == 3'h1 && mem_form) ? lcd_pkg::LCD_CLS_CX8 : lcd_pkg::LCD_CLS_UNDEF;
				[8'h60:8'h6B], 8'h6E, 8'h6F, [8'h71:8'h77], 8'h7E, 8'h7F, [8'hD1:8'hFE]:
					cls = lcd_pkg::LCD_CLS_SIMD;
				[8'h00:8'h03], 8'h06, [8'h20:8'h23], [8'h80:8'hA1], 8'hA3, 8'hA4, 8'hA5, 8'hA8, 8'hA9,
				8'hAB, 8'hAC, 8'hAD, 8'hAF, [8'hB2:8'hB7], [8'hBA:8'hBF]:
					cls = lcd_pkg::LCD_CLS_BASE;
				default: cls = lcd_pkg::LCD_CLS_UNDEF;
			endcase
		end
		else if ((b0 == 8'hDA || b0 == 8'hDB) && m >= 8'hC0 && m <= 8'hDF)
		begin
			cls = lcd_pkg::LCD_CLS_FLOAT;
		end
		else if ((b0 == 8'hDB || b0 == 8'hDF) && m >= 8'hE8 && m <= 8'hF7)
		begin
			cls = lcd_pkg::LCD_CLS_FLOAT;
		end
		else if (b0 == 8'hD6 || b0 == 8'hF1)
		begin
			cls = lcd_pkg::LCD_CLS_UNDEF;
		end
	end

	always_comb
	begin
		case (cls)
			lcd_pkg::LCD_CLS_CMOV: ok = cfg.feature[lcd_pkg::FEAT_CMOV];
			lcd_pkg::LCD_CLS_FLOAT: ok = cfg.feature[lcd_pkg::FEAT_CMOV] && cfg.feature[lcd_pkg::FEAT_FPU];
			lcd_pkg::LCD_CLS_TSC: ok = cfg.feature[lcd_pkg::FEAT_TSC];
			lcd_pkg::LCD_CLS_MSR: ok = cfg.feature[lcd_pkg::FEAT_MSR];
			lcd_pkg::LCD_CLS_CX8: ok = cfg.feature[lcd_pkg::FEAT_CX8];
			lcd_pkg::LCD_CLS_SIMD: ok = cfg.feature[lcd_pkg::FEAT_SIMD];
			lcd_pkg::LCD_CLS_PERF: ok = (cfg.family >= lcd_pkg::FAMILY_NEWER);
			lcd_pkg::LCD_CLS_QUERY: ok = cfg.has_query;
			lcd_pkg::LCD_CLS_MGMT: ok = cfg.has_mgmt;
			lcd_pkg::LCD_CLS_TRAP: ok = 1'b0;
			lcd_pkg::LCD_CLS_TESTREG: ok = 1'b0;
			lcd_pkg::LCD_CLS_UNDEF: ok = 1'b0;
			default: ok = 1'b1;
		endcase
	end

	assign dec.cls = cls;
	assign dec.fault = ~ok;

endmodule

// >>> design/lcd_flag_word.sv
/*
 processor flag word: masked writable bits, fixed bits, and the image that a
 push stores.
 assumes write data and strobes come from flops on the same clock.
*/
`timescale 1ns/1ps
module lcd_flag_word #(
	parameter bit HAS_ALIGN = 1'b1,
	parameter bit HAS_VME = 1'b1,
	parameter bit HAS_QUERY = 1'b1
) (
	input logic aclk,
	input logic aresetn,
	input logic wr_en,
	input logic [31:0] wr_data,
	input logic [3:0] wr_strb,
	input logic real_mode,
	output logic [31:0] flag_word,
	output logic [31:0] push_image
);

	localparam logic [31:0] WR_MASK = lcd_pkg::FLG_BASE_MASK
		| (32'(HAS_ALIGN) << lcd_pkg::FLG_ALIGN)
		| (32'(HAS_VME) << lcd_pkg::FLG_VINT)
		| (32'(HAS_VME) << lcd_pkg::FLG_VPEND)
		| (32'(HAS_QUERY) << lcd_pkg::FLG_QUERY);
	localparam logic [31:0] ONE_MASK = 32'h1 << lcd_pkg::FLG_FIXED_ONE;
	localparam logic [31:0] B15_MASK = 32'h1 << lcd_pkg::FLG_RSVD15;

	lcd_pkg::lcd_flag_state_t s_reg;
	lcd_pkg::lcd_flag_state_t s_next;
	logic [31:0] merged;

	always_comb
	begin
		s_next = s_reg;
		merged = lcd_pkg::lcd_merge(s_reg.word, wr_data, wr_strb);
		if (wr_en)
		begin
			s_next.word = (merged & WR_MASK) | ONE_MASK;
		end
		s_next.image = real_mode ? (s_next.word & ~B15_MASK) : s_next.word;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg <= '{word: lcd_pkg::FLG_RESET, image: lcd_pkg::FLG_RESET};
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign flag_word = s_reg.word;
	assign push_image = s_reg.image;

endmodule

// >>> design/lcd_top.sv
/*
 compatibility decode block: feature and version words, opcode validity,
 processor flag word, stack pointer push and flag push images, behind an
 AXI4-Lite slave with a sticky interrupt status.
 assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module lcd_top #(
	parameter logic [3:0] FAMILY = 4'h6,
	// model and stepping values are arbitrary
	parameter logic [3:0] MODEL = 4'h1,
	parameter logic [3:0] STEPPING = 4'h0,
	parameter bit HAS_FPU = 1'b1,
	parameter bit HAS_TSC = 1'b1,
	parameter bit HAS_MSR = 1'b1,
	parameter bit HAS_CX8 = 1'b1,
	parameter bit HAS_CMOV = 1'b1,
	parameter bit HAS_SIMD = 1'b1,
	parameter bit HAS_ALIGN = 1'b1,
	parameter bit HAS_VME = 1'b1,
	parameter bit HAS_QUERY = 1'b1,
	parameter bit HAS_MGMT = 1'b1
) (
	input logic aclk,
	input logic aresetn,
	input logic [lcd_pkg::ADDR_W-1:0] s_axi_awaddr,
	input logic [2:0] s_axi_awprot,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [lcd_pkg::ADDR_W-1:0] s_axi_araddr,
	input logic [2:0] s_axi_arprot,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	output logic irq,
	output logic invalid_opcode_fault
);

	localparam logic [31:0] FEATURE_WORD = (32'(HAS_FPU) << lcd_pkg::FEAT_FPU)
		| (32'(HAS_TSC) << lcd_pkg::FEAT_TSC)
		| (32'(HAS_MSR) << lcd_pkg::FEAT_MSR)
		| (32'(HAS_CX8) << lcd_pkg::FEAT_CX8)
		| (32'(HAS_CMOV) << lcd_pkg::FEAT_CMOV)
		| (32'(HAS_SIMD) << lcd_pkg::FEAT_SIMD);
	localparam logic [31:0] VERSION_WORD = (32'(FAMILY) << lcd_pkg::VER_FAMILY_LSB)
		| (32'(MODEL) << lcd_pkg::VER_MODEL_LSB)
		| (32'(STEPPING) << lcd_pkg::VER_STEP_LSB);
	localparam lcd_pkg::lcd_cfg_t CFG = '{
		feature: FEATURE_WORD,
		family: FAMILY,
		has_mgmt: HAS_MGMT,
		has_query: HAS_QUERY
	};

	lcd_pkg::lcd_top_state_t s_reg;
	lcd_pkg::lcd_top_state_t s_next;
	lcd_pkg::lcd_dec_out_t dec;
	logic do_write;
	logic flag_wr;
	logic [31:0] flag_word;
	logic [31:0] push_image;
	logic [lcd_pkg::IRQ_W-1:0] set_bits;
	logic [lcd_pkg::IRQ_W-1:0] clr_bits;

	lcd_decode u_decode (
		.cfg(CFG),
		.opcode(s_reg.opcode),
		.dec(dec)
	);

	lcd_flag_word #(
		.HAS_ALIGN(HAS_ALIGN),
		.HAS_VME(HAS_VME),
		.HAS_QUERY(HAS_QUERY)
	) u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(flag_wr),
		.wr_data(s_reg.w_data),
		.wr_strb(s_reg.w_strb),
		.real_mode(s_reg.real_mode),
		.flag_word(flag_word),
		.push_image(push_image)
	);

	assign do_write = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;

	always_comb
	begin
		s_next = s_reg;
		flag_wr = 1'b0;
		set_bits = '0;
		clr_bits = '0;
		s_next.fault_pulse = 1'b0;

		// address and data capture, either order
		if (s_axi_awvalid && !s_reg.aw_full)
		begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_full)
		begin
			s_next.w_full = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
		begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.rvalid && s_axi_rready)
		begin
			s_next.rvalid = 1'b0;
		end

		if (s_reg.dec_pend)
		begin
			s_next.dec_pend = 1'b0;
			s_next.result = '0;
			s_next.result[lcd_pkg::RES_DONE] = 1'b1;
			s_next.result[lcd_pkg::RES_FAULT] = dec.fault;
			s_next.result[lcd_pkg::RES_CLASS_LSB +: 4] = dec.cls;
			set_bits[lcd_pkg::IRQ_DECODE] = 1'b1;
			set_bits[lcd_pkg::IRQ_FAULT] = dec.fault;
			s_next.fault_pulse = dec.fault;
		end

		if (do_write)
		begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = lcd_pkg::RESP_OKAY;
			if (s_reg.aw_addr == lcd_pkg::OFF_OPCODE)
			begin
				s_next.opcode = lcd_pkg::OPC_W'(lcd_pkg::lcd_merge(32'(s_reg.opcode), s_reg.w_data, s_reg.w_strb));
				s_next.dec_pend = 1'b1;
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_CTRL)
			begin
				if (s_reg.w_strb[0])
				begin
					s_next.real_mode = s_reg.w_data[lcd_pkg::CTRL_REAL_MODE];
				end
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_FLAGS)
			begin
				flag_wr = 1'b1;
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_STACK)
			begin
				s_next.stack = lcd_pkg::lcd_merge(s_reg.stack, s_reg.w_data, s_reg.w_strb);
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_CMD)
			begin
				if (s_reg.w_strb[0])
				begin
					if (s_reg.w_data[lcd_pkg::CMD_PUSH_FLAGS] || s_reg.w_data[lcd_pkg::CMD_PUSH_FRAME])
					begin
						s_next.image = push_image;
						set_bits[lcd_pkg::IRQ_PUSH] = 1'b1;
					end
					if (s_reg.w_data[lcd_pkg::CMD_PUSH_STACK])
					begin
						s_next.pushed_stack = s_reg.stack;
						s_next.stack = s_reg.stack - lcd_pkg::STACK_WORD;
						set_bits[lcd_pkg::IRQ_PUSH] = 1'b1;
					end
				end
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_IRQ_STATUS)
			begin
				if (s_reg.w_strb[0])
				begin
					clr_bits = s_reg.w_data[lcd_pkg::IRQ_W-1:0];
				end
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_IRQ_MASK)
			begin
				if (s_reg.w_strb[0])
				begin
					s_next.mask = s_reg.w_data[lcd_pkg::IRQ_W-1:0];
				end
			end
			else if (s_reg.aw_addr == lcd_pkg::OFF_FEATURE || s_reg.aw_addr == lcd_pkg::OFF_VERSION
				|| s_reg.aw_addr == lcd_pkg::OFF_RESULT || s_reg.aw_addr == lcd_pkg::OFF_IMAGE
				|| s_reg.aw_addr == lcd_pkg::OFF_PUSHED)
			begin
				s_next.bresp = lcd_pkg::RESP_OKAY;
			end
			else
			begin
				s_next.bresp = lcd_pkg::RESP_SLVERR;
			end
		end

		// read side
		if (s_axi_arvalid && !s_reg.rvalid)
		begin
			s_next.rvalid = 1'b1;
			s_next.rresp = lcd_pkg::RESP_OKAY;
			s_next.rdata = '0;
			if (s_axi_araddr == lcd_pkg::OFF_FEATURE)
			begin
				s_next.rdata = FEATURE_WORD;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_VERSION)
			begin
				s_next.rdata = VERSION_WORD;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_OPCODE)
			begin
				s_next.rdata = 32'(s_reg.opcode);
			end
			else if (s_axi_araddr == lcd_pkg::OFF_RESULT)
			begin
				s_next.rdata = 32'(s_reg.result);
			end
			else if (s_axi_araddr == lcd_pkg::OFF_FLAGS)
			begin
				s_next.rdata = flag_word;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_CTRL)
			begin
				s_next.rdata[lcd_pkg::CTRL_REAL_MODE] = s_reg.real_mode;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_STACK)
			begin
				s_next.rdata = s_reg.stack;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_CMD)
			begin
				s_next.rdata = '0;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_IMAGE)
			begin
				s_next.rdata = s_reg.image;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_PUSHED)
			begin
				s_next.rdata = s_reg.pushed_stack;
			end
			else if (s_axi_araddr == lcd_pkg::OFF_IRQ_STATUS)
			begin
				s_next.rdata = 32'(s_reg.status);
			end
			else if (s_axi_araddr == lcd_pkg::OFF_IRQ_MASK)
			begin
				s_next.rdata = 32'(s_reg.mask);
			end
			else
			begin
				s_next.rresp = lcd_pkg::RESP_SLVERR;
			end
		end

		// set wins over clear
		s_next.status = (s_reg.status & ~clr_bits) | set_bits;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg <= lcd_pkg::TOP_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = !s_reg.aw_full;
	assign s_axi_wready = !s_reg.w_full;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign irq = |(s_reg.status & s_reg.mask);
	assign invalid_opcode_fault = s_reg.fault_pulse;

endmodule

// >>> test/lcd_monitor.sv
/*
 checker for the compatibility decode block: identity words, decode results,
 flag word and push images as seen on the register bus read channel.
 assumes default parameters of the top module and bind by name.
*/
`timescale 1ns/1ps
module lcd_monitor (
	input logic aclk,
	input logic aresetn,
	input logic [lcd_pkg::ADDR_W-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_bvalid,
	input logic invalid_opcode_fault
);
	logic [7:0] raddr_reg;

	// address of the read in flight
	always_ff @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready)
			raddr_reg <= s_axi_araddr;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence rd_beat(logic [7:0] a);
		s_axi_rvalid && raddr_reg == a;
	endsequence

	sequence res_beat(logic [3:0] c);
		rd_beat(lcd_pkg::OFF_RESULT) ##0 s_axi_rdata[7:4] == c;
	endsequence

	feat_move_a:
	assert property (rd_beat(lcd_pkg::OFF_FEATURE) |-> s_axi_rdata[15] && s_axi_rdata[0])
		else $error("feature word lacks move bits");
	feat_tsc_msr_a:
	assert property (rd_beat(lcd_pkg::OFF_FEATURE) |-> s_axi_rdata[5:4] == 2'h3)
		else $error("feature word lacks counter or model bits");
	feat_cx8_simd_a:
	assert property (rd_beat(lcd_pkg::OFF_FEATURE) |-> s_axi_rdata[8] && s_axi_rdata[23])
		else $error("feature word lacks exchange or packed bits");
	ver_family_a:
	assert property (rd_beat(lcd_pkg::OFF_VERSION) |-> s_axi_rdata[11:8] == lcd_pkg::FAMILY_NEWER)
		else $error("version family field wrong");
	testreg_fault_a:
	assert property (res_beat(lcd_pkg::LCD_CLS_TESTREG) |-> s_axi_rdata[1])
		else $error("test register move did not fault");
	undef_fault_a:
	assert property (res_beat(lcd_pkg::LCD_CLS_UNDEF) |-> s_axi_rdata[1])
		else $error("undefined encoding did not fault");
	fault_cause_a:
	assert property ($rose(invalid_opcode_fault) |-> $past(s_axi_bvalid) ##1 !invalid_opcode_fault)
		else $error("fault pulse without decode or too long");
	flag_fixed_a:
	assert property (rd_beat(lcd_pkg::OFF_FLAGS) |-> s_axi_rdata[31:22] == 10'h0 && !s_axi_rdata[15])
		else $error("flag word reserved bits set");
	image_clr_a:
	assert property (rd_beat(lcd_pkg::OFF_IMAGE) |-> !s_axi_rdata[15])
		else $error("pushed image bit 15 set");
	added_valid_a:
	assert property (res_beat(lcd_pkg::LCD_CLS_ADDED) |-> s_axi_rdata[1:0] == 2'h1)
		else $error("added instruction faulted");
	cache_mgmt_a:
	assert property (rd_beat(lcd_pkg::OFF_RESULT) ##0 s_axi_rdata[7:4] inside {4'h2, 4'h3} |-> !s_axi_rdata[1])
		else $error("cache or resume instruction faulted");
endmodule

bind lcd_top lcd_monitor i_lcd_monitor (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .invalid_opcode_fault(invalid_opcode_fault));

// >>> test/lcd_top_tb.sv
/*
 testbench for the compatibility decode block, driving its register bus.
 assumes the top module with default parameters and the bound checker.
*/
`timescale 1ns/1ps
module lcd_top_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq, invalid_opcode_fault;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdata_b, d_b;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures, n_compared, cyc, n_faults;

	lcd_top i_lcd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'h1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'h1), .irq(irq),
		.invalid_opcode_fault(invalid_opcode_fault));

	// second core without alignment check and virtual extensions, same bus stimulus
	lcd_top #(
		.HAS_ALIGN(1'b0),
		.HAS_VME(1'b0)
	) i_lcd_top_b (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'h1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
		.s_axi_rdata(rdata_b), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'h1), .irq(),
		.invalid_opcode_fault());

	initial
	begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end

	task automatic close_out();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ap;
		logic dp;
		@(posedge aclk);
		ap = 1'h1;
		dp = 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (ap || dp)
		begin
			@(posedge aclk);
			ap = ap && !s_axi_awready;
			dp = dp && !s_axi_wready;
			s_axi_awvalid <= ap;
			s_axi_wvalid <= dp;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		d_b = rdata_b;
		r = s_axi_rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask

	task automatic irq_chk(input logic e);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task automatic t_ids();
		logic [31:0] d;
		logic [1:0] r;
		rchk(lcd_pkg::OFF_FEATURE, 32'h0080_8131); // feature bits
		rd(lcd_pkg::OFF_VERSION, d, r);
		chk({28'h0, d[11:8]}, {28'h0, lcd_pkg::FAMILY_NEWER}); // family field
		wr(lcd_pkg::OFF_FEATURE, 32'h0, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_FEATURE, 32'h0080_8131); // feature word fixed
		rd(8'h30, d, r);
		chk({30'h0, r}, {30'h0, lcd_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		wr(8'h30, 32'h0, lcd_pkg::RESP_SLVERR);
	endtask

	task automatic t_decode();
		logic [24:0] tbl [24];
		logic [31:0] d;
		logic [1:0] r;
		int nf;
		tbl = '{25'h1C0240F, 25'h1C0260F, 25'h1000B0F, 25'h10000D6, 25'h10000F1, 25'h100040F,
			25'h000C80F, 25'h0C0C10F, 25'h0C0B10F, 25'h000080F, 25'h000090F, 25'h038010F,
			25'h000AA0F, 25'h0C0400F, 25'h000310F, 25'h000320F, 25'h000300F, 25'h008C70F,
			25'h000330F, 25'h000A20F, 25'h0C06F0F, 25'h0C000DA, 25'h0E800DB, 25'h0000090};
		nf = 0;
		foreach (tbl[i])
		begin
			wr(lcd_pkg::OFF_OPCODE, {8'h00, tbl[i][23:0]}, lcd_pkg::RESP_OKAY);
			rd(lcd_pkg::OFF_RESULT, d, r);
			chk({30'h0, d[1:0]}, {30'h0, tbl[i][24], 1'h1}); // fault bit
			nf += tbl[i][24];
		end
		repeat (2) @(posedge aclk);
		chk(n_faults, nf); // one pulse per fault
	endtask

	task automatic t_irq();
		rchk(lcd_pkg::OFF_IRQ_STATUS, 32'h3);
		irq_chk(1'h0);
		wr(lcd_pkg::OFF_IRQ_MASK, 32'h2, lcd_pkg::RESP_OKAY);
		irq_chk(1'h1);
		wr(lcd_pkg::OFF_IRQ_STATUS, 32'h2, lcd_pkg::RESP_OKAY);
		irq_chk(1'h0);
		rchk(lcd_pkg::OFF_IRQ_STATUS, 32'h1);
		wr(lcd_pkg::OFF_IRQ_MASK, 32'h1, lcd_pkg::RESP_OKAY);
		irq_chk(1'h1);
		wr(lcd_pkg::OFF_IRQ_STATUS, 32'h1, lcd_pkg::RESP_OKAY);
		irq_chk(1'h0);
	endtask

	task automatic t_flags();
		wr(lcd_pkg::OFF_FLAGS, 32'hFFFF_FFFF, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_FLAGS, lcd_pkg::FLG_BASE_MASK | lcd_pkg::FLG_RESET | 32'h003C_0000); // set
		chk(d_b, lcd_pkg::FLG_BASE_MASK | lcd_pkg::FLG_RESET | 32'h0020_0000); // absent flags clear
		wr(lcd_pkg::OFF_FLAGS, 32'h0, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_FLAGS, lcd_pkg::FLG_RESET); // clear
		wr(lcd_pkg::OFF_FLAGS, 32'h0020_0000, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_FLAGS, 32'h0020_0002); // query flag alone
		wr(lcd_pkg::OFF_FLAGS, 32'h0018_0000, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_FLAGS, 32'h0018_0002); // virtual flags placed
	endtask

	task automatic t_push();
		wr(lcd_pkg::OFF_STACK, 32'h0000_1000, lcd_pkg::RESP_OKAY);
		wr(lcd_pkg::OFF_CMD, 32'h4, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_PUSHED, 32'h0000_1000); // value before decrement
		rchk(lcd_pkg::OFF_STACK, 32'h0000_0FFC); // pointer decremented
		wr(lcd_pkg::OFF_CTRL, 32'h1, lcd_pkg::RESP_OKAY);
		wr(lcd_pkg::OFF_FLAGS, 32'h0000_F000, lcd_pkg::RESP_OKAY);
		wr(lcd_pkg::OFF_CMD, 32'h1, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_IMAGE, 32'h0000_7002); // flag push image
		wr(lcd_pkg::OFF_FLAGS, 32'h0000_5000, lcd_pkg::RESP_OKAY);
		wr(lcd_pkg::OFF_CMD, 32'h2, lcd_pkg::RESP_OKAY);
		rchk(lcd_pkg::OFF_IMAGE, 32'h0000_5002); // frame push image
		rchk(lcd_pkg::OFF_IRQ_STATUS, 32'h4); // push event status
	endtask

	always @(posedge aclk)
	begin
		cyc++;
		if (invalid_opcode_fault === 1'h1)
			n_faults++;
		if (cyc == 5000)
		begin
			failures++;
			close_out();
		end
	end

	initial
	begin
		failures = 0;
		n_compared = 0;
		cyc = 0;
		n_faults = 0;
		aresetn = 1'h0;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		t_ids();
		t_decode();
		t_irq();
		t_flags();
		t_push();
		close_out();
	end
endmodule
